/* File: rtl/fault_filter.sv */
// Persistence filter: one pulse once a condition has held for COUNT cycles
`timescale 1ns/100ps
`default_nettype none
module fault_filter #(
  parameter int COUNT = 800
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Condition and result
  input  wire logic cond,
  output logic      hit
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LIM  = CW'(COUNT);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_r;
  // Saturates so a lasting condition reports once
  wire  [CW-1:0] cnt_nxt = !cond ? '0 : (cnt_r == LIM) ? cnt_r : CW'(cnt_r + 1'b1);

  assign hit = cond && (cnt_r == LAST);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // fault_filter
`default_nettype wire

/* File: rtl/high_side_switch_control.sv */
// Control of four switched outputs: modes, pulse generators, supply and load protection
// Notes on behaviour
// - Each output is driven from its control field, a timer or a pulse generator.
// - Supply overvoltage turns all outputs off; with the recover bit set they return when it clears.
// - Supply undervoltage turns all outputs off; with the recover bit set they return when it clears.
// - Each voltage shutdown is suppressed by its own disable bit.
// - Without recover bit, a supply fault clears control fields and outputs stay off.
// - Supply faults set only the overvoltage and undervoltage flags.
// - Overcurrent held past the filter time switches that output off.
// - Overcurrent shutdown sets its flag and resets the field to off.
// - Overcurrent flags are never cleared by hardware; software clears them first.
// - Open load on an active output sets its flag; output stays on.
// - Open-load flags stay until software clears them after the condition ends.
// - Configuration written in normal mode; stop and sleep ignore changes.
// - Entering restart or fail-safe disables all outputs; software may re-enable.
// - Protection and detection stay active in stop and sleep modes.
// - Two pulse generators, each with its own 8-bit duty register.
// - Each generator runs at 200 Hz or 400 Hz, chosen independently.
// - Each output assignable to timer 1, timer 2, generator 1 or 2.
// - Pulse output starts as soon as the field selects a generator.
// - Overcurrent filter lasts sixteen microseconds of the system clock.
// - Open-load filter lasts sixty-four microseconds before a flag is set.
`timescale 1ns/100ps
`default_nettype none
`include "hss_regs.svh"
module high_side_switch_control
  import hss_pkg::*;
#(
  parameter int N_OUT     = 4,
  parameter int OC_CYC    = `OC_FILTER_CYC,
  parameter int OL_CYC    = `OL_FILTER_CYC,
  parameter int SLOW_STEP = `PWM_SLOW_STEP_CYC,
  parameter int FAST_STEP = `PWM_FAST_STEP_CYC
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Chip mode
  input  wire mode_t            chip_mode,
  // Timer sources
  input  wire logic             timer_one,
  input  wire logic             timer_two,
  // Supply and load sensing
  input  wire logic             supply_ov_detect,
  input  wire logic             supply_uv_detect,
  input  wire logic [N_OUT-1:0] overcurrent_detect,
  input  wire logic [N_OUT-1:0] open_load_detect,
  // Switch drive
  output logic      [N_OUT-1:0] switched_output
);

  // Stored state
  logic [N_OUT-1:0][2:0] code_r;
  logic [7:0]            duty_one_r;
  logic [7:0]            duty_two_r;
  logic [1:0]            freq_r;
  logic [2:0]            supply_cfg_r;
  logic [N_OUT-1:0]      oc_flag_r;
  logic [N_OUT-1:0]      ol_flag_r;
  logic                  sov_r;
  logic                  suv_r;
  logic                  fail_mode_prev_r;

  logic [N_OUT-1:0][2:0] code_nxt;
  logic [N_OUT-1:0]      drive_nxt;
  logic [N_OUT-1:0]      oc_hit;
  logic [N_OUT-1:0]      ol_hit;
  logic [N_OUT-1:0]      hw_clear;
  logic                  pwm_one;
  logic                  pwm_two;

  // Mode decode
  wire low_power  = (chip_mode == MODE_STOP) || (chip_mode == MODE_SLEEP);
  wire fail_mode  = (chip_mode == MODE_RESTART) || (chip_mode == MODE_FAIL_SAFE);
  wire fail_entry = fail_mode && !fail_mode_prev_r;

  // Write decode; configuration frozen in low power, status clears always allowed
  wire cfg_wr       = reg_wr && !low_power;
  wire wr_duty_one  = cfg_wr && (reg_addr == `ADDR_DUTY_ONE);
  wire wr_duty_two  = cfg_wr && (reg_addr == `ADDR_DUTY_TWO);
  wire wr_freq      = cfg_wr && (reg_addr == `ADDR_FREQ_SEL);
  wire wr_supply    = cfg_wr && (reg_addr == `ADDR_SUPPLY_CFG);
  wire oc_clr_wr    = reg_wr && (reg_addr == `ADDR_OC_STATUS);
  wire ol_clr_wr    = reg_wr && (reg_addr == `ADDR_OL_STATUS);
  wire sup_clr_wr   = reg_wr && (reg_addr == `ADDR_SUPPLY_STAT);

  // Supply protection
  wire ov_dis       = supply_cfg_r[`CFG_OV_DIS_BIT];
  wire uv_dis       = supply_cfg_r[`CFG_UV_DIS_BIT];
  wire recover      = supply_cfg_r[`CFG_RECOVER_BIT];
  wire ov_off       = supply_ov_detect && !ov_dis;
  wire uv_off       = supply_uv_detect && !uv_dis;
  wire supply_off   = ov_off || uv_off;
  // Clearing through the whole fault also discards writes made during it
  wire fault_clear  = supply_off && !recover;

  // Next values of the plain registers
  wire [7:0] duty_one_nxt   = wr_duty_one ? reg_wdata : duty_one_r;
  wire [7:0] duty_two_nxt   = wr_duty_two ? reg_wdata : duty_two_r;
  wire [1:0] freq_nxt       = wr_freq ? {reg_wdata[`FREQ_TWO_BIT], reg_wdata[`FREQ_ONE_BIT]} : freq_r;
  wire [2:0] supply_cfg_nxt = wr_supply ? {reg_wdata[`CFG_RECOVER_BIT], reg_wdata[`CFG_UV_DIS_BIT],
                                           reg_wdata[`CFG_OV_DIS_BIT]} : supply_cfg_r;

  // Sticky flags; a new event wins over a clear in the same cycle
  wire [N_OUT-1:0] oc_flag_nxt = oc_hit | (oc_flag_r & ~(oc_clr_wr ? reg_wdata[N_OUT-1:0] : '0));
  wire [N_OUT-1:0] ol_flag_nxt = ol_hit | (ol_flag_r & ~(ol_clr_wr ? reg_wdata[N_OUT-1:0] : '0));
  wire sov_nxt = supply_ov_detect || (sov_r && !(sup_clr_wr && reg_wdata[`STAT_OV_BIT]));
  wire suv_nxt = supply_uv_detect || (suv_r && !(sup_clr_wr && reg_wdata[`STAT_UV_BIT]));

  // Pulse generators
  pwm_gen #(
    .SLOW_STEP (SLOW_STEP),
    .FAST_STEP (FAST_STEP)
  ) u_pwm_one (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .duty      (duty_one_r),
    .fast      (freq_r[0]),
    .pwm_out   (pwm_one)
  );

  pwm_gen #(
    .SLOW_STEP (SLOW_STEP),
    .FAST_STEP (FAST_STEP)
  ) u_pwm_two (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .duty      (duty_two_r),
    .fast      (freq_r[1]),
    .pwm_out   (pwm_two)
  );

  // Per output: field write, source select, load filters
  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi = gi + 1) begin : g_out
      localparam int         LSB  = (gi % 2 == 0) ? `CTRL_LO_LSB : `CTRL_HI_LSB;
      localparam logic [7:0] ADDR = (gi < 2) ? `ADDR_CTRL_A : `ADDR_CTRL_B;

      wire       wr_field = cfg_wr && (reg_addr == ADDR);
      wire [2:0] code     = code_r[gi];
      // Hardware clears win over a software write
      assign hw_clear[gi] = oc_hit[gi] || fault_clear || fail_entry;
      assign code_nxt[gi] = hw_clear[gi] ? `RST_CODE : wr_field ? reg_wdata[LSB +: 3] : code;

      wire sel_on = (code == CODE_ON)     ? 1'b1 :
                    (code == CODE_TIMER1) ? timer_one :
                    (code == CODE_TIMER2) ? timer_two :
                    (code == CODE_PWM1)   ? pwm_one :
                    (code == CODE_PWM2)   ? pwm_two : 1'b0;
      assign drive_nxt[gi] = sel_on && !supply_off;

      // Sensing only counts while the switch is driven on
      fault_filter #(
        .COUNT   (OC_CYC)
      ) u_oc_filter (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cond    (overcurrent_detect[gi] && switched_output[gi]),
        .hit     (oc_hit[gi])
      );

      fault_filter #(
        .COUNT   (OL_CYC)
      ) u_ol_filter (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cond    (open_load_detect[gi] && switched_output[gi]),
        .hit     (ol_hit[gi])
      );
    end
  endgenerate

  // Read decode
  wire [7:0] rd_ctrl_a  = {1'b0, code_r[1], 1'b0, code_r[0]};
  wire [7:0] rd_ctrl_b  = {1'b0, code_r[3], 1'b0, code_r[2]};
  wire [7:0] rd_stat    = {2'h0, supply_uv_detect, supply_ov_detect, 2'h0, suv_r, sov_r};
  wire [7:0] rd_mux     = (reg_addr == `ADDR_CTRL_A)      ? rd_ctrl_a :
                          (reg_addr == `ADDR_CTRL_B)      ? rd_ctrl_b :
                          (reg_addr == `ADDR_DUTY_ONE)    ? duty_one_r :
                          (reg_addr == `ADDR_DUTY_TWO)    ? duty_two_r :
                          (reg_addr == `ADDR_FREQ_SEL)    ? {6'h00, freq_r} :
                          (reg_addr == `ADDR_SUPPLY_CFG)  ? {5'h00, supply_cfg_r} :
                          (reg_addr == `ADDR_OC_STATUS)   ? {4'h0, oc_flag_r} :
                          (reg_addr == `ADDR_OL_STATUS)   ? {4'h0, ol_flag_r} :
                          (reg_addr == `ADDR_SUPPLY_STAT) ? rd_stat : 8'h00;
  wire [7:0] rdata_nxt  = reg_rd ? rd_mux : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      code_r           <= '0;
      duty_one_r       <= `RST_DUTY;
      duty_two_r       <= `RST_DUTY;
      freq_r           <= `RST_FREQ;
      supply_cfg_r     <= `RST_SUPPLY_CFG;
      fail_mode_prev_r <= 1'b0;
    end else begin
      code_r           <= code_nxt;
      duty_one_r       <= duty_one_nxt;
      duty_two_r       <= duty_two_nxt;
      freq_r           <= freq_nxt;
      supply_cfg_r     <= supply_cfg_nxt;
      fail_mode_prev_r <= fail_mode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oc_flag_r       <= '0;
      ol_flag_r       <= '0;
      sov_r           <= 1'b0;
      suv_r           <= 1'b0;
      switched_output <= '0;
      reg_rdata       <= 8'h00;
    end else begin
      oc_flag_r       <= oc_flag_nxt;
      ol_flag_r       <= ol_flag_nxt;
      sov_r           <= sov_nxt;
      suv_r           <= suv_nxt;
      switched_output <= drive_nxt;
      reg_rdata       <= rdata_nxt;
    end
  end

  // Checks
  sequence s_frozen_write;
    reg_wr && (reg_addr == `ADDR_CTRL_A) && low_power && !(|hw_clear);
  endsequence

  sequence s_fail_entry;
    !fail_mode_prev_r && fail_mode;
  endsequence

  property p_ov_off;
    @(posedge clk_sys) disable iff (!reset_n)
      (supply_ov_detect && !ov_dis) |=> (switched_output == '0);
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("output on during overvoltage");

  property p_uv_off;
    @(posedge clk_sys) disable iff (!reset_n)
      (supply_uv_detect && !uv_dis) |=> (switched_output == '0);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("output on during undervoltage");

  property p_ov_disabled;
    @(posedge clk_sys) disable iff (!reset_n)
      (supply_ov_detect && ov_dis && !supply_uv_detect && (code_r[0] == CODE_ON) && !hw_clear[0])
        |=> switched_output[0];
  endproperty
  a_ov_disabled: assert property (p_ov_disabled) else $error("disabled overvoltage still switched off");

  property p_no_recover;
    @(posedge clk_sys) disable iff (!reset_n)
      (supply_off && !recover) |=> (code_r == '0);
  endproperty
  a_no_recover: assert property (p_no_recover) else $error("fields kept without recovery");

  property p_supply_flag;
    @(posedge clk_sys) disable iff (!reset_n)
      (supply_ov_detect && !(|oc_hit) && !oc_clr_wr) |=> (sov_r && (oc_flag_r == $past(oc_flag_r)));
  endproperty
  a_supply_flag: assert property (p_supply_flag) else $error("supply fault flag wrong");

  property p_oc_shutdown;
    @(posedge clk_sys) disable iff (!reset_n)
      oc_hit[0] |=> (oc_flag_r[0] && (code_r[0] == CODE_OFF)) ##1 !switched_output[0];
  endproperty
  a_oc_shutdown: assert property (p_oc_shutdown) else $error("overcurrent shutdown missing");

  property p_ol_keep;
    @(posedge clk_sys) disable iff (!reset_n)
      (ol_hit[3] && !supply_off && !oc_hit[3] && (code_r[3] == CODE_ON) && !fail_entry)
        |=> (ol_flag_r[3] && switched_output[3]);
  endproperty
  a_ol_keep: assert property (p_ol_keep) else $error("open load not flagged or output dropped");

  property p_ol_sticky;
    @(posedge clk_sys) disable iff (!reset_n)
      (ol_flag_r[3] && !ol_clr_wr) |=> ol_flag_r[3];
  endproperty
  a_ol_sticky: assert property (p_ol_sticky) else $error("open-load flag lost");

  property p_freeze;
    @(posedge clk_sys) disable iff (!reset_n)
      s_frozen_write |=> (code_r[1:0] == $past(code_r[1:0]));
  endproperty
  a_freeze: assert property (p_freeze) else $error("control changed in low power");

  property p_fail_off;
    @(posedge clk_sys) disable iff (!reset_n)
      s_fail_entry |=> (code_r == '0) ##1 (switched_output == '0);
  endproperty
  a_fail_off: assert property (p_fail_off) else $error("outputs kept on entering fail mode");

  property p_pwm_zero;
    @(posedge clk_sys) disable iff (!reset_n)
      (duty_one_r == 8'h00) && ($past(duty_one_r) == 8'h00) |-> !pwm_one;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty produced a pulse");

  // Independent run length of overcurrent on output 1, saturating
  wire         oc_cond0   = overcurrent_detect[0] && switched_output[0];
  logic [15:0] oc_run_r;
  wire  [15:0] oc_run_nxt = !oc_cond0 ? 16'h0000 : (oc_run_r == 16'hffff) ? oc_run_r : 16'(oc_run_r + 16'h0001);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oc_run_r <= 16'h0000;
    end else begin
      oc_run_r <= oc_run_nxt;
    end
  end

  property p_oc_filter;
    @(posedge clk_sys) disable iff (!reset_n)
      oc_hit[0] == (oc_cond0 && (oc_run_r == 16'(OC_CYC - 1)));
  endproperty
  a_oc_filter: assert property (p_oc_filter) else $error("overcurrent filter time wrong");

  property p_oc_off_all;
    @(posedge clk_sys) disable iff (!reset_n)
      (|oc_hit) |-> ##2 ((switched_output & $past(oc_hit, 2)) == '0);
  endproperty
  a_oc_off_all: assert property (p_oc_off_all) else $error("output still on after overcurrent");

  property p_oc_sticky;
    @(posedge clk_sys) disable iff (!reset_n)
      (oc_flag_r[2] && !oc_clr_wr) |=> oc_flag_r[2];
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent flag lost");

  property p_direct_on;
    @(posedge clk_sys) disable iff (!reset_n)
      ((code_r[1] == CODE_ON) && !supply_off) |=> switched_output[1];
  endproperty
  a_direct_on: assert property (p_direct_on) else $error("output set on but not driven");

  property p_pwm_follow;
    @(posedge clk_sys) disable iff (!reset_n)
      ((code_r[0] == CODE_PWM1) && !supply_off) |=> (switched_output[0] == $past(pwm_one));
  endproperty
  a_pwm_follow: assert property (p_pwm_follow) else $error("output not following its generator");

endmodule // high_side_switch_control
`default_nettype wire

/* File: rtl/hss_pkg.sv */
// Types shared by the switch controller
`default_nettype none
package hss_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'h0,
    MODE_STOP      = 3'h1,
    MODE_SLEEP     = 3'h2,
    MODE_RESTART   = 3'h3,
    MODE_FAIL_SAFE = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    CODE_OFF    = 3'h0,
    CODE_ON     = 3'h1,
    CODE_TIMER1 = 3'h2,
    CODE_TIMER2 = 3'h3,
    CODE_PWM1   = 3'h4,
    CODE_PWM2   = 3'h5
  } out_code_t;

endpackage
`default_nettype wire

/* File: rtl/hss_regs.svh */
// Register offsets, field positions, reset values and timing counts of the switch controller
`ifndef HSS_REGS_SVH
`define HSS_REGS_SVH

// Clock
`define CLK_SYS_HZ         50000000
`define CLK_SYS_MHZ        50

// Filter times in microseconds and their cycle counts
`define OC_FILTER_US       16
`define OL_FILTER_US       64
`define OC_FILTER_CYC      (`OC_FILTER_US * `CLK_SYS_MHZ)
`define OL_FILTER_CYC      (`OL_FILTER_US * `CLK_SYS_MHZ)

// Pulse generator frequencies and prescaler counts per duty step
`define PWM_SLOW_HZ        200
`define PWM_FAST_HZ        400
`define PWM_STEPS          256
`define PWM_SLOW_STEP_CYC  (`CLK_SYS_HZ / (`PWM_SLOW_HZ * `PWM_STEPS))
`define PWM_FAST_STEP_CYC  (`CLK_SYS_HZ / (`PWM_FAST_HZ * `PWM_STEPS))

// Register offsets
`define ADDR_CTRL_A        8'h00
`define ADDR_CTRL_B        8'h01
`define ADDR_DUTY_ONE      8'h02
`define ADDR_DUTY_TWO      8'h03
`define ADDR_FREQ_SEL      8'h04
`define ADDR_SUPPLY_CFG    8'h05
`define ADDR_OC_STATUS     8'h06
`define ADDR_OL_STATUS     8'h07
`define ADDR_SUPPLY_STAT   8'h08

// Field positions
`define CTRL_LO_LSB        0
`define CTRL_HI_LSB        4
`define FREQ_ONE_BIT       0
`define FREQ_TWO_BIT       1
`define CFG_OV_DIS_BIT     0
`define CFG_UV_DIS_BIT     1
`define CFG_RECOVER_BIT    2
`define STAT_OV_BIT        0
`define STAT_UV_BIT        1
`define STAT_OV_LIVE_BIT   4
`define STAT_UV_LIVE_BIT   5

// Reset values
`define RST_CODE           3'h0
`define RST_DUTY           8'h00
`define RST_FREQ           2'h0
`define RST_SUPPLY_CFG     3'h0

`endif

/* File: rtl/pwm_gen.sv */
// Eight-bit pulse generator with two selectable periods
`timescale 1ns/100ps
`default_nettype none
module pwm_gen #(
  parameter int SLOW_STEP = 976,
  parameter int FAST_STEP = 488
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Setting
  input  wire logic [7:0] duty,
  input  wire logic       fast,
  // Output
  output logic            pwm_out
);
  localparam int PW = $clog2(SLOW_STEP + 1);
  localparam logic [PW-1:0] SLOW_LIM = PW'(SLOW_STEP - 1);
  localparam logic [PW-1:0] FAST_LIM = PW'(FAST_STEP - 1);

  logic [PW-1:0] pre_r;
  logic [7:0]    cnt_r;
  wire  [PW-1:0] pre_lim  = fast ? FAST_LIM : SLOW_LIM;
  wire           step     = (pre_r >= pre_lim);
  wire  [PW-1:0] pre_nxt  = step ? '0 : PW'(pre_r + 1'b1);
  wire  [7:0]    cnt_nxt  = step ? 8'(cnt_r + 8'h01) : cnt_r;
  // Duty over 256 of each period; zero never turns on
  wire           pwm_nxt  = (cnt_r < duty);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pre_r   <= '0;
      cnt_r   <= 8'h00;
      pwm_out <= 1'b0;
    end else begin
      pre_r   <= pre_nxt;
      cnt_r   <= cnt_nxt;
      pwm_out <= pwm_nxt;
    end
  end
endmodule // pwm_gen
`default_nettype wire

/* File: tb/load_model.sv */
// Behavioural model of the loads hung on the four switched outputs
`timescale 1ns/100ps
`default_nettype none
module load_model (
  // Clock
  input  wire logic       clk_sys,
  // Switch drive and planned load faults
  input  wire logic [3:0] switched_output,
  input  wire logic [3:0] short_plan,
  input  wire logic [3:0] open_plan,
  input  wire logic       slow,
  // Sense lines back to the controller
  output logic      [3:0] overcurrent_detect,
  output logic      [3:0] open_load_detect
);
  logic [3:0] oc_now;
  logic [3:0] ol_now;
  logic [3:0] oc_r;
  logic [3:0] ol_r;

  // Current only flows while the switch drives the load
  assign oc_now = switched_output & short_plan;
  assign ol_now = switched_output & open_plan;

  always_ff @(posedge clk_sys) begin
    oc_r <= oc_now;
    ol_r <= ol_now;
  end

  // Slow loads report a cycle late, as a real slope would
  assign overcurrent_detect = slow ? oc_r : oc_now;
  assign open_load_detect   = slow ? ol_r : ol_now;
endmodule // load_model
`default_nettype wire

/* File: tb/test_high_side_switch_control.sv */
// Self-checking bench for the high-side switch controller
`timescale 1ns/100ps
`default_nettype none
module test_high_side_switch_control import hss_pkg::*;;
  localparam int OC = 8;
  localparam int OL = 16;
  logic        clk_sys, reset_n, reg_wr, reg_rd, timer_one, timer_two, slow;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d1, d2;
  logic [1:0]  sup, prev;
  logic [3:0]  switched_output, overcurrent_detect, open_load_detect, short_plan, open_plan;
  logic [3:0]  r1, r2;
  logic [11:0] c1, c2;
  logic [31:0] exp_q[$];
  logic [31:0] got, e, t;
  logic        pin_req, cnt_req, rd_seen, pin_seen, cnt_seen, cnt_run;
  mode_t       chip_mode;
  int          num_errors, samples_checked, cycles, seed, i, r, c;

  high_side_switch_control #(.OC_CYC(OC), .OL_CYC(OL), .SLOW_STEP(4), .FAST_STEP(2)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_mode(chip_mode),
    .timer_one(timer_one), .timer_two(timer_two), .supply_ov_detect(sup[0]),
    .supply_uv_detect(sup[1]), .overcurrent_detect(overcurrent_detect),
    .open_load_detect(open_load_detect), .switched_output(switched_output));

  load_model loads (
    .clk_sys(clk_sys), .switched_output(switched_output), .short_plan(short_plan),
    .open_plan(open_plan), .slow(slow), .overcurrent_detect(overcurrent_detect),
    .open_load_detect(open_load_detect));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task report_and_stop;
    if (exp_q.size() != 0) num_errors++;
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Monitor: pops the oldest note whenever a result stands
  always @(posedge clk_sys) begin
    if (rd_seen | pin_seen | cnt_seen) begin
      got = rd_seen ? {24'h0, reg_rdata} : pin_seen ? {28'h0, switched_output} : {r1, c1, r2, c2};
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffff_ffff;
      samples_checked++;
      if (got !== e) begin
        num_errors++;
        $display("Error at %0t: got %h expected %h", $time, got, e);
      end
    end
    rd_seen <= reg_rd;
    pin_seen <= pin_req;
    cnt_seen <= cnt_req;
    prev <= switched_output[1:0];
    if (cnt_run) begin
      c1 <= c1 + {11'h0, switched_output[0]};
      c2 <= c2 + {11'h0, switched_output[1]};
      r1 <= r1 + {3'h0, switched_output[0] & ~prev[0]};
      r2 <= r2 + {3'h0, switched_output[1] & ~prev[1]};
    end
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Each transfer leaves one idle cycle so no strobe is driven twice at an edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] x);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    exp_q.push_back({24'h0, x});
    @(posedge clk_sys);
  endtask

  task pin(input logic [3:0] x);
    pin_req <= 1'b1;
    @(posedge clk_sys);
    pin_req <= 1'b0;
    exp_q.push_back({28'h0, x});
    @(posedge clk_sys);
  endtask

  task all_on;
    wr(8'h00, 8'h11);
    wr(8'h01, 8'h11);
  endtask

  // Window of one slow period: high time and rising edges of outputs 1 and 2
  task measure(input logic [3:0] x1, input logic [3:0] x2);
    {c1, c2, r1, r2} <= '0;
    cnt_run <= 1'b1;
    step(1024);
    cnt_run <= 1'b0;
    cnt_req <= 1'b1;
    @(posedge clk_sys);
    cnt_req <= 1'b0;
    exp_q.push_back({x1, 2'h0, d1, 2'h0, x2, 2'h0, d2, 2'h0});
    @(posedge clk_sys);
  endtask

  initial begin
    seed = 4;
    reset_n = 1'b0;
    chip_mode = MODE_NORMAL;
    {reg_wr, reg_rd, timer_one, timer_two, slow, pin_req, cnt_req, cnt_run} = '0;
    {rd_seen, pin_seen, cnt_seen, reg_addr, reg_wdata, sup, short_plan, open_plan} = '0;
    {num_errors, samples_checked, cycles} = '0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    step(1);
    for (i = 0; i < 10; i++) rd(8'(i), 8'h00);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h00);
    for (c = 0; c < 8; c++) begin
      t = $random(seed);
      timer_one <= t[0];
      timer_two <= t[1];
      wr(8'h00, 8'(c));
      step(1);
      pin({3'h0, c == 1 || (c == 2 && t[0]) || (c == 3 && t[1])});
      if (c < 6) rd(8'h00, 8'(c));
    end
    // Supply faults with and without recovery, then with shutdown disabled
    for (i = 0; i < 2; i++) begin
      for (r = 0; r < 2; r++) begin
        wr(8'h05, r ? 8'h04 : 8'h00);
        all_on();
        sup[i] <= 1'b1;
        step(3);
        pin(4'h0);
        rd(8'h08, 8'h11 << i);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        sup[i] <= 1'b0;
        step(3);
        pin(r ? 4'hf : 4'h0);
        rd(8'h00, r ? 8'h11 : 8'h00);
        rd(8'h08, 8'h01 << i);
        wr(8'h08, 8'h01 << i);
        rd(8'h08, 8'h00);
      end
      wr(8'h05, 8'h01 << i);
      all_on();
      sup[i] <= 1'b1;
      step(3);
      pin(4'hf);
      rd(8'h08, 8'h11 << i);
      sup[i] <= 1'b0;
      wr(8'h08, 8'h01 << i);
    end
    wr(8'h05, 8'h00);
    // Overcurrent on output 3 with slow loads
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h01);
    slow <= 1'b1;
    timer_one <= 1'b1;
    short_plan[2] <= 1'b1;
    step(OC - 3);
    short_plan[2] <= 1'b0;
    pin(4'h4);
    short_plan[2] <= 1'b1;
    step(OC + 6);
    pin(4'h0);
    short_plan[2] <= 1'b0;
    rd(8'h01, 8'h00);
    rd(8'h06, 8'h04);
    step(OC);
    rd(8'h06, 8'h04);
    wr(8'h06, 8'h04);
    wr(8'h01, 8'h02);
    step(1);
    pin(4'h4);
    // Open load on output 4
    wr(8'h01, 8'h10);
    open_plan[3] <= 1'b1;
    step(OL - 3);
    open_plan[3] <= 1'b0;
    rd(8'h07, 8'h00);
    open_plan[3] <= 1'b1;
    step(OL + 6);
    pin(4'h8);
    rd(8'h07, 8'h08);
    open_plan[3] <= 1'b0;
    step(2);
    rd(8'h07, 8'h08);
    wr(8'h07, 8'h08);
    rd(8'h07, 8'h00);
    // Pulse generators, duty kept at four counts or more
    d1 = 8'($random(seed)) | 8'h04;
    d2 = 8'($random(seed)) | 8'h04;
    wr(8'h02, d1);
    wr(8'h03, d2);
    wr(8'h04, 8'h02);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h54);
    rd(8'h02, d1);
    rd(8'h03, d2);
    step(4);
    measure(4'h1, 4'h2);
    wr(8'h04, 8'h01);
    step(4);
    measure(4'h2, 4'h1);
    // Low-power and failure modes
    wr(8'h00, 8'h01);
    chip_mode <= MODE_STOP;
    step(1);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h01);
    pin(4'h1);
    chip_mode <= MODE_SLEEP;
    short_plan[0] <= 1'b1;
    step(OC + 6);
    pin(4'h0);
    short_plan[0] <= 1'b0;
    rd(8'h06, 8'h01);
    wr(8'h06, 8'h01);
    rd(8'h06, 8'h00);
    for (i = 0; i < 2; i++) begin
      chip_mode <= MODE_NORMAL;
      wr(8'h00, 8'h11);
      chip_mode <= i ? MODE_FAIL_SAFE : MODE_RESTART;
      step(3);
      pin(4'h0);
      rd(8'h00, 8'h00);
      wr(8'h00, 8'h01);
      step(1);
      pin(4'h1);
    end
    step(2);
    report_and_stop();
  end
endmodule // test_high_side_switch_control
`default_nettype wire
